// ==== src/pswc_top.sv ====
/*
  Power state and wake controller: one full power state and two sleep
  states, clock gating, ready flag, wake detection, wake pin and the
  wake event interrupt status, plus the PHY power-down controls.
  Assumes host strobes and line inputs are synchronous to clk_sys_i.
*/
// What this block does
// - One full-power state, two sleeps; sleeping permits only power control reads.
// - Ready flag is clear in sleep, set again only in full power.
// - After reset or wake, writes are ignored until one read occurs.
// - Any wake test write in sleep returns to full power, select to 00.
// - Writing 01 to power select enters wake-on-LAN sleep, clears ready.
// - Wake-on-LAN sleep keeps PHY, internal clock, receive block; gates MAC, host.
// - Wake-on-LAN sleep enables frame detection; detection sets wake source 10b.
// - Frame detection drives wake pin only with LAN enable and pin enable.
// - Any wake event sets the interrupt status flag whatever the pin enable.
// - Writing 10 to power select enters energy sleep, clears ready.
// - Energy sleep stops internal, MAC, host clocks; PHY in energy power-down.
// - Carrier in energy sleep sets wake source 01b; pin with both enables.
// - Carrier already present at energy sleep entry is detected at once.
// - Interrupt flag holds while the wake event persists.
// - With the event gone, writing one clears the interrupt flag.
// - Host interrupt follows the flag and its enable, not the pin.
// - Pulse select gives a 50 ms pin pulse, otherwise a steady level.
// - Pin drops when wake source, its enable or pin enable clears.
// - PHY general power-down bit holds PHY down; clearing resets it.
// - PHY energy power-down with no energy idles PHY; energy sets flag.
// - Ready is set within 2 ms after the wake test write.
`timescale 1ns/1ps
`default_nettype none
module pswc_top #(
  parameter int RESUME_CYCLES = pswc_pkg::RESUME_CYC,
  parameter int PULSE_CYCLES = pswc_pkg::PULSE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic acc_rd_i,
  input wire logic acc_wr_i,
  input wire logic [1:0] acc_target_i,
  input wire logic [1:0] wr_power_state_select_i,
  input wire logic wr_wake_on_lan_enable_i,
  input wire logic wr_energy_wake_enable_i,
  input wire logic wr_wake_pin_enable_i,
  input wire logic wr_wake_pin_pulse_select_i,
  input wire logic [1:0] wr_wake_source_clear_i,
  input wire logic wr_wake_int_clear_i,
  input wire logic wake_int_enable_i,
  input wire logic wake_frame_det_i,
  input wire logic magic_frame_det_i,
  input wire logic line_energy_present_i,
  input wire logic phy_general_powerdown_i,
  input wire logic phy_energy_powerdown_bit_i,
  input wire logic phy_energy_flag_clear_i,
  output logic device_ready_o,
  output logic rd_accept_o,
  output logic wr_accept_o,
  output logic [1:0] power_state_select_o,
  output logic [1:0] wake_source_status_o,
  output logic wake_on_lan_enable_o,
  output logic energy_wake_enable_o,
  output logic wake_pin_enable_o,
  output logic wake_pin_pulse_select_o,
  output logic wake_int_status_o,
  output logic host_irq_o,
  output logic wake_pin_o,
  output logic mac_clk_en_o,
  output logic host_if_clk_en_o,
  output logic internal_clk_en_o,
  output logic phy_clk_en_o,
  output logic rx_pm_active_o,
  output logic phy_energy_powerdown_o,
  output logic phy_powered_o,
  output logic phy_tx_enable_o,
  output logic phy_auto_reset_o,
  output logic phy_energy_flag_o
);

  localparam logic [pswc_pkg::CNT_W-1:0] RESUME_LAST =
    pswc_pkg::CNT_W'(RESUME_CYCLES - 1);
  localparam logic [pswc_pkg::CNT_W-1:0] CNT_ZERO = '0;

  pswc_pkg::pswc_state_t state_reg;
  pswc_pkg::pswc_state_t state_next;
  logic [pswc_pkg::CNT_W-1:0] resume_cnt_reg;
  logic [pswc_pkg::CNT_W-1:0] resume_cnt_next;
  logic read_seen_reg;
  logic read_seen_next;
  logic [1:0] pss_reg;
  logic [1:0] pss_next;
  logic [1:0] wss_reg;
  logic [1:0] wss_next;
  logic wake_on_lan_enable_reg;
  logic energy_wake_enable_reg;
  logic pin_en_reg;
  logic pulse_sel_reg;
  logic wint_reg;
  logic wint_next;
  logic gen_pd_reg;
  logic energy_reg;
  logic auto_reset_reg;
  logic eflag_reg;

  logic in_full;
  logic in_sleep;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_wake;
  logic wr_int;
  logic frame_hit;
  logic energy_hit;
  logic wake_event;
  logic ed_mode;
  logic ed_idle;

  pswc_pin_if pin_bus();

  // Target test used by both the read and write gates.
  function automatic logic is_target(input logic [1:0] tgt,
                                     input logic [1:0] want);
    is_target = (tgt == want);
  endfunction

  // State decodes.
  assign in_full = (state_reg == pswc_pkg::PSWC_FULL);
  assign in_sleep = (state_reg == pswc_pkg::PSWC_WOL_SLEEP) ||
                    (state_reg == pswc_pkg::PSWC_ENERGY_SLEEP);

  // Reads of anything but power control are refused when not ready; the
  // wake test write is the only write let through while not ready, and
  // nothing is written before the first read.
  assign rd_accept_o = acc_rd_i &&
    (in_full || is_target(acc_target_i, pswc_pkg::TGT_POWER_CTRL));
  assign wr_ok = acc_wr_i && read_seen_reg &&
    (in_full || is_target(acc_target_i, pswc_pkg::TGT_WAKE_TEST));
  assign wr_accept_o = wr_ok;
  assign wr_ctrl = wr_ok && in_full &&
    is_target(acc_target_i, pswc_pkg::TGT_POWER_CTRL);
  assign wr_wake = wr_ok && in_sleep &&
    is_target(acc_target_i, pswc_pkg::TGT_WAKE_TEST);
  assign wr_int = wr_ok && in_full &&
    is_target(acc_target_i, pswc_pkg::TGT_INT_STATUS);

  // Detection is armed only by the matching sleep state; energy is a
  // level, so a carrier present at entry is caught on the first cycle.
  assign frame_hit = (state_reg == pswc_pkg::PSWC_WOL_SLEEP) &&
    (wake_frame_det_i || magic_frame_det_i);
  assign energy_hit = (state_reg == pswc_pkg::PSWC_ENERGY_SLEEP) &&
    line_energy_present_i;

  // The internal wake event lasts while a source bit and its enable hold.
  assign wake_event = (wss_reg[1] && wake_on_lan_enable_reg) ||
                      (wss_reg[0] && energy_wake_enable_reg);

  // Pin condition for the timer; pin enable gates the pin only.
  assign pin_bus.cond = wake_event && pin_en_reg;
  assign pin_bus.pulse_sel = pulse_sel_reg;

  // Power state sequencing.
  always_comb begin
    state_next = state_reg;
    resume_cnt_next = resume_cnt_reg;
    pss_next = pss_reg;
    case (state_reg)
      pswc_pkg::PSWC_FULL: begin
        if (wr_ctrl) begin
          if (wr_power_state_select_i == pswc_pkg::PSS_WOL) begin
            state_next = pswc_pkg::PSWC_WOL_SLEEP;
            pss_next = pswc_pkg::PSS_WOL;
          end else if (wr_power_state_select_i == pswc_pkg::PSS_ENERGY) begin
            state_next = pswc_pkg::PSWC_ENERGY_SLEEP;
            pss_next = pswc_pkg::PSS_ENERGY;
          end
        end
      end
      pswc_pkg::PSWC_WOL_SLEEP, pswc_pkg::PSWC_ENERGY_SLEEP: begin
        if (wr_wake) begin
          state_next = pswc_pkg::PSWC_RESUMING;
          pss_next = pswc_pkg::PSS_FULL;
          resume_cnt_next = RESUME_LAST;
        end
      end
      pswc_pkg::PSWC_RESUMING: begin
        // Counting down keeps ready within the resume limit.
        if (resume_cnt_reg == CNT_ZERO) begin
          state_next = pswc_pkg::PSWC_FULL;
        end else begin
          resume_cnt_next = resume_cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = pswc_pkg::PSWC_FULL;
        pss_next = pswc_pkg::PSS_FULL;
      end
    endcase
  end

  // First-read tracking: cleared on the return to full power.
  always_comb begin
    read_seen_next = read_seen_reg;
    if (state_reg == pswc_pkg::PSWC_RESUMING) begin
      read_seen_next = 1'b0;
    end else if (acc_rd_i && rd_accept_o) begin
      read_seen_next = 1'b1;
    end
  end

  // Wake source: a detection wins over a clear in the same cycle.
  always_comb begin
    wss_next = wss_reg;
    if (wr_ctrl) begin
      wss_next = wss_reg & ~wr_wake_source_clear_i;
    end
    if (frame_hit) begin
      wss_next = pswc_pkg::WSS_FRAME;
    end else if (energy_hit) begin
      wss_next = pswc_pkg::WSS_ENERGY;
    end
  end

  // Interrupt flag: held by a live event, cleared by a one otherwise.
  always_comb begin
    wint_next = wint_reg;
    if (wr_int && wr_wake_int_clear_i) begin
      wint_next = 1'b0;
    end
    if (wake_event) begin
      wint_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_reg <= pswc_pkg::PSWC_FULL;
      resume_cnt_reg <= CNT_ZERO;
      read_seen_reg <= 1'b0;
      pss_reg <= pswc_pkg::PSS_FULL;
      wss_reg <= pswc_pkg::WSS_NONE;
      wint_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      resume_cnt_reg <= resume_cnt_next;
      read_seen_reg <= read_seen_next;
      pss_reg <= pss_next;
      wss_reg <= wss_next;
      wint_reg <= wint_next;
    end
  end

  // Enables change only through an accepted power control write.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      wake_on_lan_enable_reg <= 1'b0;
      energy_wake_enable_reg <= 1'b0;
      pin_en_reg <= 1'b0;
      pulse_sel_reg <= 1'b0;
    end else if (ce_i && wr_ctrl) begin
      wake_on_lan_enable_reg <= wr_wake_on_lan_enable_i;
      energy_wake_enable_reg <= wr_energy_wake_enable_i;
      pin_en_reg <= wr_wake_pin_enable_i;
      pulse_sel_reg <= wr_wake_pin_pulse_select_i;
    end
  end

  // PHY power-down: energy mode is the bit or the energy sleep itself.
  assign ed_mode = phy_energy_powerdown_bit_i ||
    (state_reg == pswc_pkg::PSWC_ENERGY_SLEEP);
  assign ed_idle = ed_mode && !line_energy_present_i;

  // The energy flag is sticky; a new energy edge beats the clear.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      gen_pd_reg <= 1'b0;
      energy_reg <= 1'b0;
      auto_reset_reg <= 1'b0;
      eflag_reg <= 1'b0;
    end else if (ce_i) begin
      gen_pd_reg <= phy_general_powerdown_i;
      energy_reg <= line_energy_present_i;
      auto_reset_reg <= gen_pd_reg && !phy_general_powerdown_i;
      if (ed_mode && line_energy_present_i && !energy_reg) begin
        eflag_reg <= 1'b1;
      end else if (phy_energy_flag_clear_i) begin
        eflag_reg <= 1'b0;
      end
    end
  end

  pswc_pin_timer #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_pin_timer (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .pin(pin_bus)
  );

  // Ready and clock gating follow the state directly.
  assign device_ready_o = in_full;
  assign mac_clk_en_o = in_full;
  assign host_if_clk_en_o = in_full;
  assign internal_clk_en_o =
    (state_reg != pswc_pkg::PSWC_ENERGY_SLEEP);
  assign phy_clk_en_o = internal_clk_en_o;
  assign rx_pm_active_o = in_full ||
    (state_reg == pswc_pkg::PSWC_WOL_SLEEP);
  assign phy_energy_powerdown_o = ed_mode;
  assign phy_powered_o = !phy_general_powerdown_i && !ed_idle;
  assign phy_tx_enable_o = phy_powered_o;
  assign phy_auto_reset_o = auto_reset_reg;
  assign phy_energy_flag_o = eflag_reg;

  // Status readback and interrupt.
  assign power_state_select_o = pss_reg;
  assign wake_source_status_o = wss_reg;
  assign wake_on_lan_enable_o = wake_on_lan_enable_reg;
  assign energy_wake_enable_o = energy_wake_enable_reg;
  assign wake_pin_enable_o = pin_en_reg;
  assign wake_pin_pulse_select_o = pulse_sel_reg;
  assign wake_int_status_o = wint_reg;
  assign host_irq_o = wint_reg && wake_int_enable_i;
  assign wake_pin_o = pin_bus.active;

endmodule
`default_nettype wire

// ==== src/pswc_pkg.sv ====
/*
  Constants shared by the power state and wake controller: power state
  select codes, wake source codes, access targets and timing figures.
  Assumes a 100 MHz system clock; nothing else is needed around it.
*/
package pswc_pkg;

  // Clock rate in MHz.
  localparam int CLK_MHZ = 100;

  // Power state select field codes.
  localparam logic [1:0] PSS_FULL = 2'h0;
  localparam logic [1:0] PSS_WOL = 2'h1;
  localparam logic [1:0] PSS_ENERGY = 2'h2;

  // Wake source status codes.
  localparam logic [1:0] WSS_NONE = 2'h0;
  localparam logic [1:0] WSS_ENERGY = 2'h1;
  localparam logic [1:0] WSS_FRAME = 2'h2;

  // Access targets presented with each host read or write strobe.
  localparam logic [1:0] TGT_POWER_CTRL = 2'h0;
  localparam logic [1:0] TGT_WAKE_TEST = 2'h1;
  localparam logic [1:0] TGT_INT_STATUS = 2'h2;
  localparam logic [1:0] TGT_OTHER = 2'h3;

  // Longest time from the wake write to the ready flag, in microseconds.
  localparam int RESUME_TIME_US = 2000;
  localparam int RESUME_CYC = RESUME_TIME_US * CLK_MHZ;

  // Width of the wake pin pulse, in milliseconds.
  localparam int PULSE_TIME_MS = 50;
  localparam int PULSE_CYC = PULSE_TIME_MS * 1000 * CLK_MHZ;

  // Counter width able to hold both counts.
  localparam int CNT_W = 23;

  // Controller states.
  typedef enum logic [1:0] {
    PSWC_FULL,
    PSWC_WOL_SLEEP,
    PSWC_ENERGY_SLEEP,
    PSWC_RESUMING
  } pswc_state_t;

endpackage

// ==== src/pswc_pin_if.sv ====
/*
  Carrier between the controller and its wake pin timer: the pin
  condition, the pulse select and the timed pin level coming back.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface pswc_pin_if;
  logic cond;
  logic pulse_sel;
  logic active;
  modport ctl(output cond, output pulse_sel, input active);
  modport tmr(input cond, input pulse_sel, output active);
endinterface
`default_nettype wire

// ==== src/pswc_pin_timer.sv ====
/*
  Wake pin timer: drives the pin level from the wake condition, either
  as a fixed width pulse or as a steady level.
  Assumes synchronous active low reset and a shared clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
module pswc_pin_timer #(
  parameter int PULSE_CYCLES = pswc_pkg::PULSE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  pswc_pin_if.tmr pin
);

  localparam logic [pswc_pkg::CNT_W-1:0] LOAD =
    pswc_pkg::CNT_W'(PULSE_CYCLES - 1);
  localparam logic [pswc_pkg::CNT_W-1:0] ZERO = '0;

  logic cond_reg;
  logic active_reg;
  logic active_next;
  logic [pswc_pkg::CNT_W-1:0] cnt_reg;
  logic [pswc_pkg::CNT_W-1:0] cnt_next;
  logic rise;
  logic cnt_done;

  // A new pulse starts only on a fresh rise of the condition.
  assign rise = pin.cond & ~cond_reg;
  assign cnt_done = (cnt_reg == ZERO);

  // Level mode follows the condition; pulse mode times out.
  always_comb begin
    active_next = 1'b0;
    cnt_next = cnt_reg;
    if (!pin.cond) begin
      active_next = 1'b0;
      cnt_next = ZERO;
    end else if (!pin.pulse_sel) begin
      active_next = 1'b1;
    end else if (rise) begin
      active_next = 1'b1;
      cnt_next = LOAD;
    end else if (active_reg && !cnt_done) begin
      active_next = 1'b1;
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cond_reg <= 1'b0;
      active_reg <= 1'b0;
      cnt_reg <= ZERO;
    end else if (ce_i) begin
      cond_reg <= pin.cond;
      active_reg <= active_next;
      cnt_reg <= cnt_next;
    end
  end

  assign pin.active = active_reg;

endmodule
`default_nettype wire

// ==== sim/pswc_top_checker.sv ====
/*
  Concurrent checks on the power state and wake controller top ports.
  Assumes the bind below and one clock domain with clock enable high.
*/
`timescale 1ns/1ps
`default_nettype none
module pswc_top_checker #(
  parameter int RESUME_CYCLES = 8,
  parameter int PULSE_CYCLES = 5
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic acc_rd_i,
  input wire logic [1:0] acc_target_i,
  input wire logic wake_int_enable_i,
  input wire logic phy_general_powerdown_i,
  input wire logic device_ready_o,
  input wire logic rd_accept_o,
  input wire logic wr_accept_o,
  input wire logic [1:0] power_state_select_o,
  input wire logic mac_clk_en_o,
  input wire logic internal_clk_en_o,
  input wire logic phy_energy_powerdown_o,
  input wire logic wake_int_status_o,
  input wire logic host_irq_o,
  input wire logic wake_pin_enable_o,
  input wire logic wake_pin_pulse_select_o,
  input wire logic wake_pin_o,
  input wire logic phy_powered_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i || !ce_i);
  int res_cnt_reg;
  int pin_cnt_reg;
  wire logic wake_wr = !device_ready_o && wr_accept_o &&
    acc_target_i == pswc_pkg::TGT_WAKE_TEST;
  // Cycle counters: resume wait and pin high time are too long to unroll.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || device_ready_o) res_cnt_reg <= 0;
    else if (res_cnt_reg != 0 || wake_wr) res_cnt_reg <= res_cnt_reg + 1;
    pin_cnt_reg <= (!rst_b_i || !wake_pin_o) ? 0 : pin_cnt_reg + 1;
  end
  sequence wake_wr_s;
    !device_ready_o && wr_accept_o &&
      acc_target_i == pswc_pkg::TGT_WAKE_TEST;
  endsequence
  ready_in_sleep_a:
    assert property (power_state_select_o != 2'h0 |-> !device_ready_o)
    else $error("ready flag set while asleep");
  sleep_read_gate_a:
    assert property (acc_rd_i && !device_ready_o && acc_target_i != 2'h0
      |-> !rd_accept_o) else $error("read accepted while asleep");
  wol_clocks_a:
    assert property (power_state_select_o == pswc_pkg::PSS_WOL
      |-> !mac_clk_en_o && internal_clk_en_o)
    else $error("wake-on-LAN clock gating wrong");
  energy_clocks_a:
    assert property (power_state_select_o == pswc_pkg::PSS_ENERGY
      |-> !internal_clk_en_o && phy_energy_powerdown_o)
    else $error("energy sleep gating wrong");
  wake_write_a:
    assert property (wake_wr_s |=> power_state_select_o == 2'h0)
    else $error("wake write left select set");
  resume_time_a:
    assert property (res_cnt_reg <= RESUME_CYCLES + 2)
    else $error("ready too late after wake write");
  irq_follow_a:
    assert property (host_irq_o == (wake_int_status_o && wake_int_enable_i))
    else $error("host interrupt mismatch");
  pin_drop_a:
    assert property (!wake_pin_enable_o |=> !wake_pin_o)
    else $error("pin active without pin enable");
  pulse_len_a:
    assert property (wake_pin_pulse_select_o && wake_pin_o
      |-> pin_cnt_reg < PULSE_CYCLES) else $error("pin pulse too long");
  phy_down_a:
    assert property (phy_general_powerdown_i |-> !phy_powered_o)
    else $error("phy powered in power-down");
endmodule
bind pswc_top pswc_top_checker #(.RESUME_CYCLES(RESUME_CYCLES),
  .PULSE_CYCLES(PULSE_CYCLES)) chk_u (.clk_sys_i, .rst_b_i, .ce_i,
  .acc_rd_i, .acc_target_i, .wake_int_enable_i, .phy_general_powerdown_i,
  .device_ready_o, .rd_accept_o, .wr_accept_o, .power_state_select_o,
  .mac_clk_en_o, .internal_clk_en_o, .phy_energy_powerdown_o,
  .wake_int_status_o, .host_irq_o, .wake_pin_enable_o,
  .wake_pin_pulse_select_o, .wake_pin_o, .phy_powered_o);
`default_nettype wire

// ==== sim/pswc_line_model.sv ====
/*
  Network line side: turns bench requests into receive detection pulses
  and a carrier level, one clock late as real receive logic would be.
  Assumes requests change away from the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pswc_line_model (
  input wire logic clk_sys_i,
  input wire logic frame_req_i,
  input wire logic magic_req_i,
  input wire logic carrier_i,
  output logic wake_frame_det_o,
  output logic magic_frame_det_o,
  output logic line_energy_present_o
);
  // Detections are registered so they never race the controller.
  always_ff @(posedge clk_sys_i) begin
    wake_frame_det_o <= frame_req_i;
    magic_frame_det_o <= magic_req_i;
    line_energy_present_o <= carrier_i;
  end
endmodule
`default_nettype wire

// ==== sim/test_pswc_top.sv ====
/*
  Self-checking bench for the power state and wake controller.
  Assumes the package, the pin interface and the line model are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t mismatch", $time); end end
module test_pswc_top;
  logic clk_sys_i, rst_b_i, ce_i, acc_rd_i, acc_wr_i, ok;
  logic [1:0] acc_target_i, wr_power_state_select_i, wr_wake_source_clear_i;
  logic wr_wake_on_lan_enable_i, wr_energy_wake_enable_i;
  logic wr_wake_pin_enable_i, wr_wake_pin_pulse_select_i;
  logic wr_wake_int_clear_i, wake_int_enable_i, wake_frame_det_i;
  logic magic_frame_det_i, line_energy_present_i, phy_general_powerdown_i;
  logic phy_energy_powerdown_bit_i, phy_energy_flag_clear_i;
  logic device_ready_o, rd_accept_o, wr_accept_o, wake_on_lan_enable_o;
  logic [1:0] power_state_select_o, wake_source_status_o;
  logic energy_wake_enable_o, wake_pin_enable_o, wake_pin_pulse_select_o;
  logic wake_int_status_o, host_irq_o, wake_pin_o, mac_clk_en_o;
  logic host_if_clk_en_o, internal_clk_en_o, phy_clk_en_o, rx_pm_active_o;
  logic phy_energy_powerdown_o, phy_powered_o, phy_tx_enable_o;
  logic phy_auto_reset_o, phy_energy_flag_o, frame_req, magic_req, carrier;
  int failures = 0, cmp_count = 0, cycles = 0, n;
  // Short counts keep the resume wait and the pin pulse cheap to simulate.
  pswc_top #(.RESUME_CYCLES(8), .PULSE_CYCLES(5)) dut_u (.clk_sys_i,
    .rst_b_i, .ce_i, .acc_rd_i, .acc_wr_i, .acc_target_i,
    .wr_power_state_select_i, .wr_wake_on_lan_enable_i,
    .wr_energy_wake_enable_i, .wr_wake_pin_enable_i,
    .wr_wake_pin_pulse_select_i, .wr_wake_source_clear_i,
    .wr_wake_int_clear_i, .wake_int_enable_i, .wake_frame_det_i,
    .magic_frame_det_i, .line_energy_present_i, .phy_general_powerdown_i,
    .phy_energy_powerdown_bit_i, .phy_energy_flag_clear_i, .device_ready_o,
    .rd_accept_o, .wr_accept_o, .power_state_select_o,
    .wake_source_status_o, .wake_on_lan_enable_o, .energy_wake_enable_o,
    .wake_pin_enable_o, .wake_pin_pulse_select_o, .wake_int_status_o,
    .host_irq_o, .wake_pin_o, .mac_clk_en_o, .host_if_clk_en_o,
    .internal_clk_en_o, .phy_clk_en_o, .rx_pm_active_o,
    .phy_energy_powerdown_o, .phy_powered_o, .phy_tx_enable_o,
    .phy_auto_reset_o, .phy_energy_flag_o);
  pswc_line_model line_u (.clk_sys_i, .frame_req_i(frame_req),
    .magic_req_i(magic_req), .carrier_i(carrier),
    .wake_frame_det_o(wake_frame_det_i),
    .magic_frame_det_o(magic_frame_det_i),
    .line_energy_present_o(line_energy_present_i));
  // Clock, and a ceiling far above the hundred or so cycles the run needs.
  initial begin
    clk_sys_i = 0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  // One strobe per access; accept is combinational, so sample it mid-cycle.
  task automatic acc(input logic rd, input logic wr, input logic [1:0] t);
    @(negedge clk_sys_i);
    acc_rd_i = rd;
    acc_wr_i = wr;
    acc_target_i = t;
    #1 ok = rd ? rd_accept_o : wr_accept_o;
    @(negedge clk_sys_i);
    acc_rd_i = 0;
    acc_wr_i = 0;
  endtask
  task automatic ctl(input logic [1:0] s, input logic [3:0] en,
    input logic [1:0] clr);
    wr_power_state_select_i = s;
    {wr_wake_on_lan_enable_i, wr_energy_wake_enable_i} = en[3:2];
    {wr_wake_pin_enable_i, wr_wake_pin_pulse_select_i} = en[1:0];
    wr_wake_source_clear_i = clr;
    acc(0, 1, pswc_pkg::TGT_POWER_CTRL);
  endtask
  // The host polls ready before anything else after a wake write.
  task automatic wait_ready();
    n = 0;
    while (device_ready_o !== 1'b1 && n < 50) begin
      cyc(1);
      n++;
    end
    `CHK(n <= 11, 1'b1)
  endtask
  task automatic give_verdict();
    $display("Counts: %0d failures, %0d compares", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {acc_rd_i, acc_wr_i, acc_target_i, wr_wake_int_clear_i, carrier} = 0;
    {wr_power_state_select_i, wr_wake_source_clear_i, frame_req} = 0;
    magic_req = 0;
    {wr_wake_on_lan_enable_i, wr_energy_wake_enable_i} = 0;
    {wr_wake_pin_enable_i, wr_wake_pin_pulse_select_i} = 0;
    {wake_int_enable_i, phy_general_powerdown_i} = 0;
    {phy_energy_powerdown_bit_i, phy_energy_flag_clear_i} = 0;
    ce_i = 1;
    rst_b_i = 0;
    cyc(10);
    rst_b_i = 1;
    `CHK({device_ready_o, power_state_select_o}, 3'b100)
    ctl(pswc_pkg::PSS_WOL, 4'hA, 2'h0);
    `CHK({ok, power_state_select_o}, 3'b000)
    acc(1, 0, pswc_pkg::TGT_INT_STATUS);
    acc(0, 1, pswc_pkg::TGT_WAKE_TEST);
    `CHK({ok, device_ready_o, power_state_select_o}, 4'hC)
    // A frozen clock enable must keep the sleep request from landing.
    ce_i = 0;
    ctl(pswc_pkg::PSS_WOL, 4'hA, 2'h0);
    ce_i = 1;
    `CHK({device_ready_o, power_state_select_o}, 3'b100)
    ctl(pswc_pkg::PSS_WOL, 4'hA, 2'h0);
    `CHK(power_state_select_o, pswc_pkg::PSS_WOL)
    `CHK({device_ready_o, mac_clk_en_o, host_if_clk_en_o, internal_clk_en_o,
      rx_pm_active_o}, 5'h03)
    `CHK({wake_on_lan_enable_o, energy_wake_enable_o, wake_pin_enable_o,
      wake_pin_pulse_select_o}, 4'hA)
    acc(1, 0, pswc_pkg::TGT_OTHER);
    `CHK(ok, 1'b0)
    acc(1, 0, pswc_pkg::TGT_POWER_CTRL);
    `CHK(ok, 1'b1)
    acc(0, 1, pswc_pkg::TGT_POWER_CTRL);
    `CHK(ok, 1'b0)
    wake_int_enable_i = 1;
    frame_req = 1;
    cyc(1);
    frame_req = 0;
    cyc(4);
    `CHK({wake_source_status_o, wake_pin_o, wake_int_status_o, host_irq_o},
      {pswc_pkg::WSS_FRAME, 3'b111})
    acc(0, 1, pswc_pkg::TGT_WAKE_TEST);
    `CHK(power_state_select_o, pswc_pkg::PSS_FULL)
    wait_ready();
    ctl(pswc_pkg::PSS_FULL, 4'h8, 2'h0);
    `CHK(ok, 1'b0)
    acc(1, 0, pswc_pkg::TGT_POWER_CTRL);
    wr_wake_int_clear_i = 1;
    acc(0, 1, pswc_pkg::TGT_INT_STATUS);
    `CHK(wake_int_status_o, 1'b1)
    ctl(pswc_pkg::PSS_FULL, 4'h8, 2'h0);
    cyc(1);
    `CHK(wake_pin_o, 1'b0)
    ctl(pswc_pkg::PSS_FULL, 4'h8, 2'h3);
    acc(0, 1, pswc_pkg::TGT_INT_STATUS);
    `CHK({wake_source_status_o, wake_int_status_o}, 3'b000)
    // Second wake-on-LAN sleep, woken by the other detection kind.
    ctl(pswc_pkg::PSS_WOL, 4'h8, 2'h0);
    magic_req = 1;
    cyc(1);
    magic_req = 0;
    cyc(2);
    `CHK(wake_source_status_o, pswc_pkg::WSS_FRAME)
    acc(0, 1, pswc_pkg::TGT_WAKE_TEST);
    wait_ready();
    acc(1, 0, pswc_pkg::TGT_POWER_CTRL);
    ctl(pswc_pkg::PSS_FULL, 4'h0, 2'h3);
    // Carrier is already on the line before the energy sleep is entered.
    phy_energy_powerdown_bit_i = 1;
    carrier = 1;
    ctl(pswc_pkg::PSS_ENERGY, 4'h7, 2'h0);
    n = 0;
    repeat (20) begin
      cyc(1);
      n += (wake_pin_o === 1'b1);
    end
    `CHK(n == 5, 1'b1)
    `CHK({device_ready_o, internal_clk_en_o, mac_clk_en_o, host_if_clk_en_o,
      phy_clk_en_o, phy_energy_powerdown_o}, 6'h01)
    `CHK({wake_on_lan_enable_o, energy_wake_enable_o, wake_pin_enable_o,
      wake_pin_pulse_select_o}, 4'h7)
    `CHK(wake_source_status_o, pswc_pkg::WSS_ENERGY)
    acc(0, 1, pswc_pkg::TGT_WAKE_TEST);
    wait_ready();
    phy_energy_powerdown_bit_i = 0;
    phy_general_powerdown_i = 1;
    cyc(1);
    `CHK(phy_powered_o, 1'b0)
    phy_general_powerdown_i = 0;
    n = 0;
    repeat (4) begin
      cyc(1);
      n += (phy_auto_reset_o === 1'b1);
    end
    `CHK(n == 1, 1'b1)
    phy_energy_powerdown_bit_i = 1;
    carrier = 0;
    cyc(2);
    `CHK(phy_tx_enable_o, 1'b0)
    // The flag is still set from the energy sleep entry, so clear it first.
    phy_energy_flag_clear_i = 1;
    cyc(1);
    phy_energy_flag_clear_i = 0;
    `CHK(phy_energy_flag_o, 1'b0)
    carrier = 1;
    cyc(3);
    `CHK({phy_tx_enable_o, phy_energy_flag_o}, 2'b11)
    give_verdict();
  end
endmodule
`default_nettype wire
